// *** logic/rail_seq_supervisor.sv ***
// rail on/off sequencing, restart hold-off and overcurrent supervision
`timescale 1ns/1ps
// What this block does
// - current above fault limit declares overcurrent fault
// - current is sense minus reference over gain
// - no overcurrent fault while ramping up or down
// - average current above warning sets warning, alert
// - no overcurrent warning while ramping up or down
// - run falling edge: hold run low, then restart
// - hold-off 136 ms to 65.52 s, 16 ms steps
// - wait turn-on delay, at most 83 s
// - rise over rise time; tiny times step
// - turn-on timeout fault unless above undervoltage
// - setpoint changes slew at the transition rate
// - divider variant ramps at transition rate too
// - wait turn-off delay, at most 16 s
// - fall linearly to zero, then disable rail
// - slow descent after fall raises warning, alert
// - zero disables turn-off check, else 120 ms-524 s
// - parameters are two-byte exponent-mantissa words
// - input undervoltage status bit reads zero
module rail_seq_supervisor #(
  parameter int TICK_CYCLES = rsq_pkg::TICK_CYCLES, // clocks per 0.25 ms
  parameter bit DIVIDER_SET = 1'b0  // divider-set variant
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire rsq_pkg::cmd_req_type cmd,
  output logic [15:0]               cmd_rdata,
  output logic                      cmd_rvalid,
  input  wire logic                 run_in,
  output logic                      run_out,
  output logic                      run_oe,
  input  wire logic                 operation_on,
  input  wire logic                 off_immediate,
  input  wire logic [15:0]          vout_target_mv,
  input  wire logic                 vout_above_uv,
  input  wire logic                 vout_below_eighth,
  input  wire logic [15:0]          current_sense_input,
  input  wire logic [15:0]          current_sense_reference,
  input  wire logic [15:0]          adc_avg_current,
  input  wire logic                 adc_valid,
  input  wire logic [3:0]           alert_mask,
  output logic [15:0]               setpoint_mv,
  output logic                      rail_enable,
  output logic                      alert_n
);
  localparam int CW = rsq_pkg::CNT_W;
  localparam int SW = rsq_pkg::SP_W;
  localparam int DW = $clog2(TICK_CYCLES);

  logic [15:0]        regs_r [rsq_pkg::N_REGS]; // command words
  logic [CW-1:0]      dec [rsq_pkg::N_REGS];    // decoded values
  logic [DW-1:0]      div_r;          // tick divider
  logic               tick_r;         // one pulse per 0.25 ms
  logic [2:0]         sync1_r;        // pin synchroniser, first stage
  logic [2:0]         sync2_r;        // run, above uv, below eighth
  logic               run_prev_r;     // run level one clock ago
  logic               hold_act_r;     // run pin being pulled low
  logic [CW-1:0]      hold_cnt_r;
  rsq_pkg::state_type state_r;
  rsq_pkg::state_type state_nxt;
  logic [CW-1:0]      phase_cnt_r;    // ticks since phase entry
  logic [SW-1:0]      sp_r;           // setpoint, mV with fraction
  logic [CW-1:0]      err_r;          // linear ramp accumulator
  logic               ton_arm_r;
  logic [CW-1:0]      ton_cnt_r;
  logic               toff_arm_r;
  logic [CW-1:0]      toff_cnt_r;
  rsq_pkg::status_type sticky_r;      // latched events
  rsq_pkg::status_type ev_set;
  rsq_pkg::status_type ev_clr;
  logic               rail_en_r;
  logic               alert_n_r;
  logic               run_out_r;
  logic [15:0]        rdata_r;
  logic               rvalid_r;

  // each parameter word decodes from its exponent-mantissa form
  genvar gi;
  generate
    for (gi = 0; gi < rsq_pkg::N_REGS; gi++) begin : g_dec
      linear_decode #(
        .FRAC  (rsq_pkg::FRAC_OF[gi]),
        .OUT_W (CW)
      ) u_dec (
        .word  (regs_r[gi]),
        .value (dec[gi])
      );
    end
  endgenerate

  // parameter words, written whole as two data bytes
  always_ff @(posedge clk) begin
    for (int i = 0; i < rsq_pkg::N_REGS; i++) begin
      if (!reset_n) begin
        regs_r[i] <= rsq_pkg::RESET_OF[i];
      end else if (cmd.valid && cmd.write &&
                   cmd.code == rsq_pkg::CODE_OF[i]) begin
        regs_r[i] <= cmd.wdata;
      end
    end
  end

  // clamp a decoded time into its valid window
  function automatic logic [CW-1:0] clamp(input logic [CW-1:0] v,
                                          input int lo_ms,
                                          input int hi_ms);
    logic [CW-1:0] lo;
    logic [CW-1:0] hi;
    lo = CW'(lo_ms * rsq_pkg::TICKS_PER_MS);
    hi = CW'(hi_ms * rsq_pkg::TICKS_PER_MS);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // effective times in ticks
  logic [CW-1:0] hold_q;
  logic [CW-1:0] ton_dly_q;
  logic [CW-1:0] rise_q;
  logic [CW-1:0] ton_max_q;
  logic [CW-1:0] toff_dly_q;
  logic [CW-1:0] fall_q;
  logic [CW-1:0] toff_warn_q;
  logic [CW-1:0] ramp_q;
  logic [SW-1:0] step_q;        // slew per tick
  logic [SW-1:0] target_q;
  logic [SW-1:0] goal_q;
  always_comb begin
    hold_q = dec[rsq_pkg::R_HOLDOFF] & ~CW'(rsq_pkg::HOLDOFF_STEP_MS *
             rsq_pkg::TICKS_PER_MS - 1);
    hold_q = clamp(hold_q, rsq_pkg::HOLDOFF_MIN_MS,
                   rsq_pkg::HOLDOFF_MAX_MS);
    ton_dly_q = clamp(dec[rsq_pkg::R_TON_DLY], 0,
                      rsq_pkg::TURN_ON_DELAY_MAX_MS);
    rise_q = clamp(dec[rsq_pkg::R_RISE], 0,
                   rsq_pkg::RAMP_MAX_MS);
    ton_max_q = clamp(dec[rsq_pkg::R_TON_MAX], 0,
                      rsq_pkg::TON_MAX_MAX_MS);
    toff_dly_q = clamp(dec[rsq_pkg::R_TOFF_DLY], 0,
                       rsq_pkg::TURN_OFF_DELAY_MAX_MS);
    fall_q = clamp(dec[rsq_pkg::R_FALL], 0,
                   rsq_pkg::RAMP_MAX_MS);
    // zero stays zero: it switches the check off
    toff_warn_q = (dec[rsq_pkg::R_TOFF_WARN] == '0) ? '0 :
                  clamp(dec[rsq_pkg::R_TOFF_WARN],
                        rsq_pkg::TOFF_WARN_MIN_MS,
                        rsq_pkg::TOFF_WARN_MAX_MS);
    ramp_q = (state_r == rsq_pkg::ST_FALL) ? fall_q : rise_q;
    step_q = SW'(dec[rsq_pkg::R_SLEW] * rsq_pkg::RATE_MV_PER_TICK);
    target_q = {vout_target_mv, rsq_pkg::SP_FRAC'(0)};
    goal_q = (state_r == rsq_pkg::ST_FALL) ? '0 : target_q;
  end

  // shared quarter-ms time base for every delay and timeout
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r == DW'(TICK_CYCLES - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // pins and analog comparators cross in through two flops
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r    <= 3'h0;
      sync2_r    <= 3'h0;
      run_prev_r <= 1'b0;
    end else begin
      sync1_r    <= {vout_below_eighth, vout_above_uv, run_in};
      sync2_r    <= sync1_r;
      run_prev_r <= sync2_r[0];
    end
  end

  // hold-off: a run falling edge pulls the pin low for the delay
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hold_act_r <= 1'b0;
      hold_cnt_r <= '0;
    end else if (run_prev_r && !sync2_r[0]) begin
      hold_act_r <= 1'b1;
      hold_cnt_r <= '0;
    end else if (hold_act_r && tick_r) begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
      if (hold_cnt_r + 1'b1 >= hold_q) begin
        hold_act_r <= 1'b0;
      end
    end
  end

  // ramp end: slew variant reaches its goal, else the time runs out
  logic start_req;
  logic ramping;
  logic ramp_done;
  always_comb begin
    start_req = sync2_r[0] && operation_on && !hold_act_r;
    ramping = (state_r == rsq_pkg::ST_RISE) ||
              (state_r == rsq_pkg::ST_FALL);
    if (DIVIDER_SET) begin
      ramp_done = ramping && (sp_r == goal_q);
    end else begin
      ramp_done = ramping && (ramp_q == '0 ||
                              phase_cnt_r >= ramp_q);
    end
  end

  // sequencing phases
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rsq_pkg::ST_OFF: begin
        if (start_req) state_nxt = rsq_pkg::ST_ON_DELAY;
      end
      rsq_pkg::ST_ON_DELAY: begin
        if (!start_req) begin
          state_nxt = rsq_pkg::ST_OFF;
        end else if (phase_cnt_r >= ton_dly_q) begin
          state_nxt = rsq_pkg::ST_RISE;
        end
      end
      rsq_pkg::ST_RISE, rsq_pkg::ST_ON: begin
        if (!start_req) begin
          state_nxt = off_immediate ? rsq_pkg::ST_OFF :
                                      rsq_pkg::ST_OFF_DELAY;
        end else if (ramp_done) begin
          state_nxt = rsq_pkg::ST_ON;
        end
      end
      rsq_pkg::ST_OFF_DELAY: begin
        if (off_immediate) begin
          state_nxt = rsq_pkg::ST_OFF;
        end else if (phase_cnt_r >= toff_dly_q) begin
          state_nxt = rsq_pkg::ST_FALL;
        end
      end
      rsq_pkg::ST_FALL: begin
        if (off_immediate || ramp_done) begin
          state_nxt = rsq_pkg::ST_OFF;
        end
      end
    endcase
  end

  // state register and the per-phase tick counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= rsq_pkg::ST_OFF;
      phase_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        phase_cnt_r <= '0;
      end else if (tick_r && phase_cnt_r != '1) begin
        phase_cnt_r <= phase_cnt_r + 1'b1;
      end
    end
  end

  // setpoint: slews in regulation, linear or slewed on ramps
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sp_r  <= '0;
      err_r <= '0;
    end else if (state_r == rsq_pkg::ST_OFF ||
                 state_r == rsq_pkg::ST_ON_DELAY) begin
      sp_r  <= '0;
      err_r <= '0;
    end else if (ramp_done) begin
      // ramp ends exactly on its goal; short ramps are one step
      sp_r  <= goal_q;
      err_r <= '0;
    end else if (state_r == rsq_pkg::ST_ON ||
                 (DIVIDER_SET && ramping)) begin
      if (tick_r && sp_r < goal_q) begin
        sp_r <= (goal_q - sp_r > step_q) ? sp_r + step_q
                                         : goal_q;
      end else if (tick_r && sp_r > goal_q) begin
        sp_r <= (sp_r - goal_q > step_q) ? sp_r - step_q
                                         : goal_q;
      end
    end else if (ramping) begin
      // spread target millivolts evenly over the ramp ticks
      if (tick_r) begin
        err_r <= err_r + CW'(vout_target_mv);
      end else if (err_r >= ramp_q) begin
        err_r <= err_r - ramp_q;
        if (state_r == rsq_pkg::ST_RISE && sp_r < target_q) begin
          sp_r <= sp_r + SW'(1 << rsq_pkg::SP_FRAC);
        end else if (state_r == rsq_pkg::ST_FALL &&
                     sp_r >= SW'(1 << rsq_pkg::SP_FRAC)) begin
          sp_r <= sp_r - SW'(1 << rsq_pkg::SP_FRAC);
        end
      end
    end
  end

  // turn-on timeout, timed from the start of the rise
  logic ton_hit;
  logic toff_hit;
  assign ton_hit  = ton_arm_r && !sync2_r[1] && ton_cnt_r >= ton_max_q;
  assign toff_hit = toff_arm_r && !sync2_r[2] &&
                    toff_cnt_r >= toff_warn_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ton_arm_r <= 1'b0;
      ton_cnt_r <= '0;
    end else if (state_r != rsq_pkg::ST_RISE &&
                 state_nxt == rsq_pkg::ST_RISE) begin
      ton_arm_r <= (ton_max_q != '0);
      ton_cnt_r <= '0;
    end else if (sync2_r[1] || ton_hit ||
                 (state_r != rsq_pkg::ST_RISE &&
                  state_r != rsq_pkg::ST_ON)) begin
      ton_arm_r <= 1'b0;
    end else if (ton_arm_r && tick_r) begin
      ton_cnt_r <= ton_cnt_r + 1'b1;
    end
  end

  // turn-off descent check, armed when a normal fall ends
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      toff_arm_r <= 1'b0;
      toff_cnt_r <= '0;
    end else if (state_r == rsq_pkg::ST_FALL &&
                 state_nxt == rsq_pkg::ST_OFF && !off_immediate) begin
      toff_arm_r <= (toff_warn_q != '0);
      toff_cnt_r <= '0;
    end else if (sync2_r[2] || toff_hit ||
                 state_r != rsq_pkg::ST_OFF) begin
      toff_arm_r <= 1'b0;
    end else if (toff_arm_r && tick_r) begin
      toff_cnt_r <= toff_cnt_r + 1'b1;
    end
  end

  // overcurrent compare: sense minus reference against limit x gain
  logic signed [16:0] sense_diff;
  logic [47:0]        sense_lhs;
  logic [47:0]        limit_rhs;
  always_comb begin
    sense_diff = $signed({1'b0, current_sense_input}) -
                 $signed({1'b0, current_sense_reference});
    sense_lhs  = 48'(sense_diff[15:0]) << (2 * rsq_pkg::CUR_FRAC);
    limit_rhs  = 48'(dec[rsq_pkg::R_OC_FAULT]) *
                 48'(dec[rsq_pkg::R_GAIN]);
    ev_set.oc_fault = state_r == rsq_pkg::ST_ON && !sense_diff[16] &&
                      sense_lhs > limit_rhs;
    ev_set.oc_warn  = state_r == rsq_pkg::ST_ON && adc_valid &&
                      CW'(adc_avg_current) >
                      dec[rsq_pkg::R_OC_WARN];
    ev_set.ton_fault = ton_hit;
    ev_set.toff_warn = toff_hit;
  end

  // clears: the fault-clear command, or writing ones to a status byte
  logic wr;
  always_comb begin
    wr = cmd.valid && cmd.write;
    ev_clr = '0;
    if (wr && cmd.code == rsq_pkg::CMD_CLEAR_FAULTS) begin
      ev_clr = '1;
    end
    if (wr && cmd.code == rsq_pkg::CMD_STATUS_IOUT) begin
      ev_clr.oc_fault = cmd.wdata[rsq_pkg::SI_OC_FAULT];
      ev_clr.oc_warn  = cmd.wdata[rsq_pkg::SI_OC_WARN];
    end
    if (wr && cmd.code == rsq_pkg::CMD_STATUS_VOUT) begin
      ev_clr.ton_fault = cmd.wdata[rsq_pkg::SV_TON_FAULT];
      ev_clr.toff_warn = cmd.wdata[rsq_pkg::SV_TOFF_WARN];
    end
  end

  // sticky events; a new event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sticky_r <= '0;
    end else begin
      sticky_r <= (sticky_r & ~ev_clr) | ev_set;
    end
  end

  // status read-back
  logic [7:0]  st_byte;
  logic [15:0] rd_word;
  always_comb begin
    st_byte = 8'h00;
    st_byte[rsq_pkg::SB_OFF] = (state_r == rsq_pkg::ST_OFF ||
                                state_r == rsq_pkg::ST_ON_DELAY);
    st_byte[rsq_pkg::SB_IOUT_OC] = sticky_r.oc_fault;
    st_byte[rsq_pkg::SB_VIN_UV]  = 1'b0;
    rd_word = 16'h0000; // unknown codes read zero
    for (int i = 0; i < rsq_pkg::N_REGS; i++) begin
      if (cmd.code == rsq_pkg::CODE_OF[i]) rd_word = regs_r[i];
    end
    unique case (cmd.code)
      rsq_pkg::CMD_STATUS_BYTE: rd_word = {8'h00, st_byte};
      rsq_pkg::CMD_STATUS_WORD: begin
        rd_word = {sticky_r.ton_fault | sticky_r.toff_warn,
                   sticky_r.oc_fault | sticky_r.oc_warn,
                   6'h00, st_byte};
      end
      rsq_pkg::CMD_STATUS_VOUT: begin
        rd_word[rsq_pkg::SV_TON_FAULT] = sticky_r.ton_fault;
        rd_word[rsq_pkg::SV_TOFF_WARN] = sticky_r.toff_warn;
      end
      rsq_pkg::CMD_STATUS_IOUT: begin
        rd_word[rsq_pkg::SI_OC_FAULT] = sticky_r.oc_fault;
        rd_word[rsq_pkg::SI_OC_WARN]  = sticky_r.oc_warn;
      end
      default: ;
    endcase
  end

  // registered outputs: read answer, rail enable, alert, run pin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r   <= 16'h0000;
      rvalid_r  <= 1'b0;
      rail_en_r <= 1'b0;
      alert_n_r <= 1'b1;
      run_out_r <= 1'b0;
    end else begin
      rvalid_r  <= cmd.valid && !cmd.write;
      if (cmd.valid && !cmd.write) rdata_r <= rd_word;
      rail_en_r <= state_nxt != rsq_pkg::ST_OFF &&
                   state_nxt != rsq_pkg::ST_ON_DELAY;
      alert_n_r <= ~|(sticky_r & ~alert_mask);
      run_out_r <= 1'b0; // the pin is only ever pulled low
    end
  end

  assign cmd_rdata   = rdata_r;
  assign cmd_rvalid  = rvalid_r;
  assign run_out     = run_out_r;
  assign run_oe      = hold_act_r;
  assign setpoint_mv = sp_r[SW-1:rsq_pkg::SP_FRAC];
  assign rail_enable = rail_en_r;
  assign alert_n     = alert_n_r;
endmodule

// *** include/rsq_pkg.sv ***
// shared constants and types for the rail sequencing supervisor
package rsq_pkg;
  // clock and sequencing time base
  localparam int CLK_PERIOD_PS  = 5000;      // 200 MHz system clock
  localparam int TICK_PERIOD_PS = 250000000; // 0.25 ms sequencing tick
  localparam int TICK_CYCLES    = TICK_PERIOD_PS / CLK_PERIOD_PS;
  localparam int TICKS_PER_MS   = 4;

  // fraction bits kept after decoding a linear word
  localparam int TIME_FRAC = 2;   // times in quarter ms
  localparam int CUR_FRAC  = 2;   // amps and milliohms in quarters
  localparam int RATE_FRAC = 10;  // slew rate in V/ms
  localparam int SP_FRAC   = 10;  // setpoint fraction bits below 1 mV
  localparam int SP_W      = 16 + SP_FRAC;
  localparam int CNT_W     = 24;  // decoded value and counter width
  localparam int RATE_MV_PER_TICK = 250; // 1 V/ms over a quarter ms

  // documented limits, in ms
  localparam int HOLDOFF_MIN_MS    = 136;
  localparam int HOLDOFF_MAX_MS    = 65520;
  localparam int HOLDOFF_STEP_MS   = 16;
  localparam int TURN_ON_DELAY_MAX_MS  = 83000;
  localparam int RAMP_MAX_MS       = 1300;
  localparam int TON_MAX_MAX_MS    = 8000;
  localparam int TURN_OFF_DELAY_MAX_MS = 16000;
  localparam int TOFF_WARN_MIN_MS  = 120;
  localparam int TOFF_WARN_MAX_MS  = 524000;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7A;
  localparam logic [7:0] CMD_STATUS_IOUT  = 8'h7B;

  // register file indices
  localparam int N_REGS    = 11;
  localparam int R_SLEW    = 0;
  localparam int R_TON_DLY = 1;
  localparam int R_RISE    = 2;
  localparam int R_TON_MAX = 3;
  localparam int R_TOFF_DLY = 4;
  localparam int R_FALL    = 5;
  localparam int R_TOFF_WARN = 6;
  localparam int R_HOLDOFF = 7;
  localparam int R_OC_FAULT = 8;
  localparam int R_OC_WARN = 9;
  localparam int R_GAIN    = 10;
  localparam logic [7:0] CODE_OF [N_REGS] = '{8'h27, 8'h60, 8'h61,
    8'h62, 8'h64, 8'h65, 8'h66, 8'hDC, 8'h46, 8'h4A, 8'h38};
  localparam logic [15:0] RESET_OF [N_REGS] = '{16'h82BF, 16'h8000,
    16'hD200, 16'hD280, 16'h8000, 16'hD200, 16'h8000, 16'hFBE8,
    16'hDBB8, 16'hDA80, 16'hCA80};
  localparam int FRAC_OF [N_REGS] = '{RATE_FRAC, TIME_FRAC, TIME_FRAC,
    TIME_FRAC, TIME_FRAC, TIME_FRAC, TIME_FRAC, TIME_FRAC, CUR_FRAC,
    CUR_FRAC, CUR_FRAC};

  // status bit positions
  localparam int SB_OFF = 6;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_VIN_UV = 3;
  localparam int SI_OC_FAULT = 7;
  localparam int SI_OC_WARN = 5;
  localparam int SV_TON_FAULT = 4;
  localparam int SV_TOFF_WARN = 3;

  // command port request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } cmd_req_type;

  // sticky events, also the order of the alert mask bits
  typedef struct packed {
    logic toff_warn;
    logic ton_fault;
    logic oc_warn;
    logic oc_fault;
  } status_type;

  typedef enum logic [2:0] {
    ST_OFF, ST_ON_DELAY, ST_RISE, ST_ON, ST_OFF_DELAY, ST_FALL
  } state_type;
endpackage

// *** logic/linear_decode.sv ***
// exponent-mantissa word to a saturating unsigned fixed-point value
`timescale 1ns/1ps
module linear_decode #(
  parameter int FRAC  = 2,  // fraction bits kept in the result
  parameter int OUT_W = 24  // result width
) (
  input  wire logic [15:0]      word,
  output logic      [OUT_W-1:0] value
);
  logic signed [5:0]  shift;  // exponent plus kept fraction bits
  logic        [10:0] mant;   // negative mantissa counts as zero
  logic        [63:0] wide;   // unsaturated result

  // shift the mantissa, then saturate into the output width
  always_comb begin
    shift = $signed({word[15], word[15:11]}) + 6'(FRAC);
    mant  = word[10] ? 11'h000 : word[10:0];
    if (shift >= 0) begin
      wide = 64'(mant) << shift;
    end else begin
      wide = 64'(mant) >> 6'(-shift);
    end
    value = (|wide[63:OUT_W]) ? {OUT_W{1'b1}} : wide[OUT_W-1:0];
  end
endmodule

// *** tb/rsq_assertions.sv ***
// port checker bound to the rail supervisor
`timescale 1ns/1ps
module rsq_assertions #(
  parameter int TICK_CYCLES = 8 // clocks per quarter-ms tick
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire rsq_pkg::cmd_req_type cmd,
  input wire logic                 cmd_rvalid,
  input wire logic [15:0]          cmd_rdata,
  input wire logic                 run_oe,
  input wire logic                 run_out,
  input wire logic                 rail_enable,
  input wire logic                 operation_on,
  input wire logic [3:0]           alert_mask,
  input wire logic                 alert_n,
  input wire logic [15:0]          setpoint_mv,
  input wire logic [15:0]          vout_target_mv
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shortest hold-off, less one tick since the tick runs free
  localparam int HMIN = (rsq_pkg::HOLDOFF_MIN_MS * rsq_pkg::TICKS_PER_MS
                         - 1) * TICK_CYCLES;
  logic [31:0] oe_cnt_r; // cycles of run pull-down
  // restarts when the pull-down is released
  always_ff @(posedge clk) begin
    if (!reset_n || !run_oe) begin
      oe_cnt_r <= '0;
    end else begin
      oe_cnt_r <= oe_cnt_r + 32'h1;
    end
  end
  property p_rd_ans; cmd.valid && !cmd.write |=> cmd_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_no_spur; !(cmd.valid && !cmd.write) |=> !cmd_rvalid; endproperty
  a_no_spur: assert property (p_no_spur) else $error("stray answer");
  property p_uv_zero;
    cmd.valid && !cmd.write && cmd.code == rsq_pkg::CMD_STATUS_BYTE
      |=> !cmd_rdata[rsq_pkg::SB_VIN_UV];
  endproperty
  a_uv_zero: assert property (p_uv_zero) else $error("uv bit set");
  property p_run_low; run_oe |-> !run_out; endproperty
  a_run_low: assert property (p_run_low) else $error("run not low");
  property p_no_start; run_oe && !rail_enable |=> !rail_enable; endproperty
  a_no_start: assert property (p_no_start) else $error("start in hold");
  property p_hold_min; $fell(run_oe) && $past(reset_n) |-> oe_cnt_r >= HMIN;
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold too short");
  property p_masked; $past(alert_mask) == 4'hF |-> alert_n; endproperty
  a_masked: assert property (p_masked) else $error("masked alert");
  property p_off_zero;
    !rail_enable && !$past(rail_enable) |-> setpoint_mv == 16'h0000;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("setpoint off");
  property p_sp_cap; rail_enable |-> setpoint_mv <= vout_target_mv; endproperty
  a_sp_cap: assert property (p_sp_cap) else $error("setpoint over");
  property p_start_on; $rose(rail_enable) |-> operation_on && !run_oe;
  endproperty
  a_start_on: assert property (p_start_on) else $error("bad start");
  c_rise: cover property ($rose(rail_enable));
  c_hold: cover property ($fell(run_oe));
  c_alert: cover property ($fell(alert_n));
endmodule
bind rail_seq_supervisor rsq_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// *** tb/pmbus_host.sv ***
// command-port host issuing one word per read or write
`timescale 1ns/1ps
module pmbus_host (
  input  wire logic            clk,
  output rsq_pkg::cmd_req_type cmd,
  input  wire logic [15:0]     cmd_rdata,
  input  wire logic            cmd_rvalid
);
  initial cmd = '0;
  // one-edge request; reply read just after the next edge
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    cmd <= '{valid: 1'b1, write: w, code: c, wdata: d};
    @(posedge clk);
    cmd <= '0;
    #1;
    q = cmd_rvalid ? cmd_rdata : 16'hXXXX;
  endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the rail supervisor
`timescale 1ns/1ps
module tb;
  localparam int T = 8; // short tick
  logic clk = 0, reset_n = 0, run_in = 0, operation_on = 0, adc_valid = 0;
  logic off_immediate = 0, vout_above_uv = 0, vout_below_eighth = 0;
  logic run_out, run_oe, cmd_rvalid, rail_enable, alert_n;
  logic [3:0] alert_mask = 4'hF;
  logic [15:0] vout_target_mv = 16'h0000, adc_avg_current = 16'h0000;
  logic [15:0] current_sense_input = 16'h02EE; // 150 mV over reference
  logic [15:0] current_sense_reference = 16'h0258;
  logic [15:0] cmd_rdata, setpoint_mv, q;
  logic [31:0] seed = 32'hF719;
  rsq_pkg::cmd_req_type cmd;
  int failures = 0, num_checks = 0, n, m;
  always #2.5 clk = ~clk;
  rail_seq_supervisor #(.TICK_CYCLES(T)) i_rail_seq_supervisor (.*);
  pmbus_host i_pmbus_host (.clk(clk), .cmd(cmd), .cmd_rdata(cmd_rdata),
                           .cmd_rvalid(cmd_rvalid));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // cycles for ms at the bench tick
  function automatic int cyc(input int ms);
    return ms * rsq_pkg::TICKS_PER_MS * T;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic win(input int v, input int lo, input int hi);
    chk({15'h0, v >= lo && v <= hi}, 16'h0001);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_pmbus_host.xfer(1'b1, c, d, q);
  endtask
  task automatic rd(input logic [7:0] c);
    i_pmbus_host.xfer(1'b0, c, 16'h0000, q);
  endtask
  // bounded wait for a rail enable level
  task automatic wait_en(input logic lvl);
    n = 0;
    while (rail_enable !== lvl && n < 9000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    // defaults, random readback, then defaults again
    for (int i = 0; i < rsq_pkg::N_REGS; i++) begin
      rd(rsq_pkg::CODE_OF[i]);
      chk(q, rsq_pkg::RESET_OF[i]);
      seed = lfsr(seed);
      wr(rsq_pkg::CODE_OF[i], seed[15:0]);
      rd(rsq_pkg::CODE_OF[i]);
      chk(q, seed[15:0]);
      wr(rsq_pkg::CODE_OF[i], rsq_pkg::RESET_OF[i]);
    end
    rd(8'hD0);
    chk(q, 16'h0000);
    rd(rsq_pkg::CMD_STATUS_BYTE);
    chk({q[6], q[3]}, 2'b10);
    wr(8'h60, 16'h0001); // 1 ms on delay, rise and timeout
    wr(8'h61, 16'h0001);
    wr(8'h62, 16'h0001);
    wr(8'h65, 16'h0000); // zero fall steps straight down
    wr(8'h66, 16'h0001); // below range, so 120 ms applies
    wr(8'hDC, 16'h0001); // becomes 136 ms
    vout_target_mv <= {6'h00, seed[25:16]} + 16'h0100;
    alert_mask <= 4'h0;
    operation_on <= 1'b1;
    run_in <= 1'b1;
    wait_en(1'b1);
    win(n, cyc(1) - T, cyc(1) + T + 4);
    repeat (8) @(posedge clk);
    adc_avg_current <= 16'h00C8;
    adc_valid <= 1'b1;
    @(posedge clk) adc_valid <= 1'b0;
    rd(rsq_pkg::CMD_STATUS_IOUT);
    chk(q, 16'h0000);
    current_sense_input <= 16'h02EC; // just under the fault limit
    n = 0;
    while (setpoint_mv !== vout_target_mv && n < 500) begin
      @(posedge clk);
      n++;
    end
    win(n + 11, cyc(1) - T, cyc(1) + T);
    repeat (4) @(posedge clk);
    rd(rsq_pkg::CMD_STATUS_IOUT);
    chk(q, 16'h0000);
    rd(rsq_pkg::CMD_STATUS_VOUT);
    chk(q[4], 1'b1);
    vout_above_uv <= 1'b1;
    alert_mask <= 4'hF;
    current_sense_input <= 16'h02EE;
    adc_avg_current <= 16'h0051; // one quarter amp over warning
    adc_valid <= 1'b1;
    @(posedge clk) adc_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(alert_n, 1'b1);
    rd(rsq_pkg::CMD_STATUS_IOUT);
    chk(q, 16'h00A0);
    rd(rsq_pkg::CMD_STATUS_WORD);
    chk({q[15:14], q[6:3]}, 6'b110010);
    alert_mask <= 4'h0;
    current_sense_input <= 16'h0258;
    repeat (2) @(posedge clk);
    chk(alert_n, 1'b0);
    wr(rsq_pkg::CMD_CLEAR_FAULTS, 16'h0000);
    rd(rsq_pkg::CMD_STATUS_IOUT);
    chk(q, 16'h0000);
    chk(alert_n, 1'b1);
    run_in <= 1'b0;
    wait_en(1'b0);
    m = n;
    win(n, 2, 2 * T + 6);
    chk(setpoint_mv, 16'h0000);
    repeat (50) @(posedge clk);
    run_in <= 1'b1; // a start inside the hold-off must wait
    n = 0;
    while (run_oe === 1'b1 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    win(n + m + 50, cyc(136) - T, cyc(136) + T + 4);
    chk(rail_enable, 1'b0);
    rd(rsq_pkg::CMD_STATUS_VOUT);
    chk({q[3], alert_n}, 2'b10);
    wait_en(1'b1);
    chk(rail_enable, 1'b1);
    tally_and_finish();
  end
endmodule
